// [rtl/audio_port_pkg.sv]
// Shared types, constants and helpers for the serial audio output port
package audio_port_pkg;

  // ******************************************************************
  // Modes, formats and pin groups
  // ******************************************************************
  typedef enum logic [1:0] {RATIO_256, RATIO_384, RATIO_512} ratio_t;
  typedef enum logic [1:0] {FMT_LJ20, FMT_I2S20, FMT_RJ16, FMT_RJ20} format_t;

  localparam logic [1:0] IFACE_SLAVE = 2'h0;
  localparam logic [1:0] IFACE_M512 = 2'h1;
  localparam logic [1:0] IFACE_M384 = 2'h2;
  localparam logic [1:0] IFACE_M256 = 2'h3;

  typedef struct packed {
    logic bit_clock;
    logic lr;
    logic fv;
  } serial_pins_t;

  // ******************************************************************
  // Counts and reset values
  // ******************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_HOLD_CYCLES = 1024;
  localparam logic [10:0] HOLD_LAST = 11'(RESET_HOLD_CYCLES - 1);
  localparam int VALID_FRAMES_DEFAULT = 18436;
  localparam logic [9:0] FILTER_RATE = 10'h100;
  localparam logic [9:0] RATIO_THR_384 = 10'h140;
  localparam logic [9:0] RATIO_THR_512 = 10'h1C0;
  localparam logic [4:0] WORD_MSB = 5'h13;

  // ******************************************************************
  // Register map
  // ******************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LEFT = 8'h08;
  localparam logic [7:0] REG_RIGHT = 8'h0C;
  localparam int CTRL_MUTE_BIT = 0;
  localparam int CTRL_SOFT_RST_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // ******************************************************************
  // Helpers
  // ******************************************************************
  function automatic logic [9:0] cycles_per_frame(input ratio_t r);
    case (r)
      RATIO_384: cycles_per_frame = 10'h180;
      RATIO_512: cycles_per_frame = 10'h200;
      default: cycles_per_frame = 10'h100;
    endcase
  endfunction

  // Last divider count of one bit clock period (4, 6 or 8 cycles)
  function automatic logic [2:0] bit_div_last(input ratio_t r);
    case (r)
      RATIO_384: bit_div_last = 3'h5;
      RATIO_512: bit_div_last = 3'h7;
      default: bit_div_last = 3'h3;
    endcase
  endfunction

  function automatic logic [2:0] bit_div_half(input ratio_t r);
    case (r)
      RATIO_384: bit_div_half = 3'h2;
      RATIO_512: bit_div_half = 3'h3;
      default: bit_div_half = 3'h1;
    endcase
  endfunction

  // Slots of a 32-bit half frame that carry data bits
  function automatic logic slot_active(input format_t f,
                                       input logic [4:0] s);
    case (f)
      FMT_LJ20: slot_active = (s <= 5'h13);
      FMT_I2S20: slot_active = (s >= 5'h01) && (s <= 5'h14);
      FMT_RJ16: slot_active = (s >= 5'h10);
      default: slot_active = (s >= 5'h0C);
    endcase
  endfunction

endpackage

// [rtl/ratio_unit.sv]
// Clock ratio detection and the 256 fs filter rate divider
`timescale 1ns/10ps
module ratio_unit
  import audio_port_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic halt_i, // Holds the unit idle
  input wire logic master_i, // Master operation
  input wire ratio_t mode_ratio_i, // Ratio chosen by the mode pins
  input wire logic lr_rise_i, // Channel clock rising edge
  output ratio_t ratio_o, // Ratio in use
  output logic filter_tick_o // One pulse per 256 fs period
);

  // ******************************************************************
  // Ratio detection
  // ******************************************************************
  logic [9:0] span_q;
  ratio_t det_q;
  logic [9:0] acc_q;
  logic [10:0] acc_sum;

  // Period is measured in system clocks between channel clock rises
  always_ff @(posedge clk_i) begin
    if (halt_i) begin
      span_q <= 10'h000;
      det_q <= RATIO_256;
    end else if (lr_rise_i) begin
      span_q <= 10'h000;
      if (span_q < RATIO_THR_384) begin
        det_q <= RATIO_256;
      end else if (span_q < RATIO_THR_512) begin
        det_q <= RATIO_384;
      end else begin
        det_q <= RATIO_512;
      end
    end else if (span_q != 10'h3FF) begin
      span_q <= span_q + 10'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (halt_i) begin
      ratio_o <= RATIO_256;
    end else begin
      ratio_o <= master_i ? mode_ratio_i : det_q;
    end
  end

  // ******************************************************************
  // Filter rate divider
  // ******************************************************************
  // Phase accumulator gives 256 ticks per frame for any ratio
  assign acc_sum = {1'b0, acc_q} + {1'b0, FILTER_RATE};

  always_ff @(posedge clk_i) begin
    if (halt_i) begin
      acc_q <= 10'h000;
      filter_tick_o <= 1'b0;
    end else if (acc_sum >= {1'b0, cycles_per_frame(ratio_o)}) begin
      acc_q <= 10'(acc_sum - {1'b0, cycles_per_frame(ratio_o)});
      filter_tick_o <= 1'b1;
    end else begin
      acc_q <= acc_sum[9:0];
      filter_tick_o <= 1'b0;
    end
  end

endmodule

// [rtl/audio_port.sv]
// Reset sequencing, serial audio output port and APB register slave
//
// What this block does
// - Ratio of system clock detected automatically in slave mode
// - Slave mode divides clock down to 256 fs
// - Low reset pin starts the reset sequence
// - Data zero in reset and 1024 cycles after
// - Valid data 18436 frames after reset ends
// - Logic and filter halted during reset
// - Mode pins pick slave or master ratio
// - Master drives bit, channel, frame clocks
// - Frame valid spans first to last bit
// - Frame valid twice channel rate, length duty
// - Master gives 64 bit clocks per frame
// - Slave frames hold 64, 48 or 32 bits
// - Slave shifts only while frame valid high
// - Format pins pick one of four formats
// - Data changes after bit clock falling edges
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/10ps
module audio_port
  import audio_port_pkg::*;
#(
  parameter int VALID_FRAMES = VALID_FRAMES_DEFAULT
) (
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic sys_rst_i, // Synchronous reset, active high
  input wire logic reset_n_in_i, // External reset pin, active low
  input wire logic iface_sel_hi_i, // Interface mode pin, high bit
  input wire logic iface_sel_lo_i, // Interface mode pin, low bit
  input wire logic format_sel_hi_i, // Format pin, high bit
  input wire logic format_sel_lo_i, // Format pin, low bit
  input wire serial_pins_t pins_i, // Bit, channel, frame pins in
  output serial_pins_t pins_o, // Bit, channel, frame pins out
  output serial_pins_t pins_oe_o, // Output enables, high drives
  output logic data_out_o, // Serial data out
  input wire logic sample_valid_i, // New sample pair strobe
  input wire logic [19:0] sample_left_i, // Left sample
  input wire logic [19:0] sample_right_i, // Right sample
  output logic filter_tick_o, // 256 fs filter rate pulse
  output logic filter_run_o, // Filter and modulator enable
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o // APB error, unmapped address
);

  typedef enum {ST_RESET, ST_WAKE, ST_SETTLE, ST_RUN} state_t;

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  serial_pins_t ser_s1_q;
  serial_pins_t ser_s2_q;

  always_ff @(posedge clk_i) begin
    pin_s1_q <= {reset_n_in_i, iface_sel_hi_i, iface_sel_lo_i,
                 format_sel_hi_i, format_sel_lo_i};
    pin_s2_q <= pin_s1_q;
    ser_s1_q <= pins_i;
    ser_s2_q <= ser_s1_q;
  end

  // ******************************************************************
  // Reset sequencer
  // ******************************************************************
  state_t state_q;
  logic [10:0] hold_cnt_q;
  logic [15:0] frame_cnt_q;
  logic master_q;
  ratio_t mode_ratio_q;
  format_t format_q;
  logic [1:0] ctrl_q;
  logic hold_req;
  logic core_on;
  logic lr_rise;

  // The pin relies on the clock already running when it rises
  assign hold_req = ~pin_s2_q[4] | ctrl_q[CTRL_SOFT_RST_BIT];
  assign core_on = (state_q == ST_SETTLE) || (state_q == ST_RUN);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_RESET;
      hold_cnt_q <= 11'h000;
      frame_cnt_q <= 16'h0000;
    end else if (hold_req) begin
      state_q <= ST_RESET;
      hold_cnt_q <= 11'h000;
      frame_cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_RESET: begin
          state_q <= ST_WAKE;
        end
        ST_WAKE: begin
          if (hold_cnt_q == HOLD_LAST) begin
            state_q <= ST_SETTLE;
          end else begin
            hold_cnt_q <= hold_cnt_q + 11'h001;
          end
        end
        ST_SETTLE: begin
          if (frame_cnt_q == 16'(VALID_FRAMES)) begin
            state_q <= ST_RUN;
          end else if (lr_rise) begin
            frame_cnt_q <= frame_cnt_q + 16'h0001;
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_RESET;
        end
      endcase
    end
  end

  // Straps are caught once, on the way out of reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      master_q <= 1'b0;
      mode_ratio_q <= RATIO_256;
      format_q <= FMT_LJ20;
    end else if (state_q == ST_RESET && !hold_req) begin
      master_q <= (pin_s2_q[3:2] != IFACE_SLAVE);
      case (pin_s2_q[3:2])
        IFACE_M512: mode_ratio_q <= RATIO_512;
        IFACE_M384: mode_ratio_q <= RATIO_384;
        default: mode_ratio_q <= RATIO_256;
      endcase
      format_q <= format_t'(pin_s2_q[1:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      filter_run_o <= 1'b0;
      pins_oe_o <= '0;
    end else begin
      filter_run_o <= core_on;
      pins_oe_o <= {3{master_q}};
    end
  end

  // ******************************************************************
  // Ratio unit
  // ******************************************************************
  ratio_t ratio;

  ratio_unit u_ratio (
    .clk_i(clk_i),
    .halt_i(sys_rst_i | ~core_on),
    .master_i(master_q),
    .mode_ratio_i(mode_ratio_q),
    .lr_rise_i(lr_rise),
    .ratio_o(ratio),
    .filter_tick_o(filter_tick_o)
  );

  // ******************************************************************
  // Master clock generator
  // ******************************************************************
  logic [2:0] div_q;
  logic [5:0] bitn_q;
  logic [5:0] bitn_nx;

  assign bitn_nx = bitn_q + 6'h01;

  // Outputs stay low while halted so the bus sees a quiet link
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !core_on || !master_q) begin
      div_q <= 3'h0;
      // Parked one before slot 0 so the first frame after wake is whole
      bitn_q <= '1;
      pins_o <= '0;
    end else if (div_q == bit_div_last(ratio)) begin
      div_q <= 3'h0;
      bitn_q <= bitn_nx;
      pins_o.bit_clock <= 1'b0;
      pins_o.lr <= (format_q == FMT_I2S20) ? bitn_nx[5] : ~bitn_nx[5];
      pins_o.fv <= slot_active(format_q, bitn_nx[4:0]);
    end else begin
      div_q <= div_q + 3'h1;
      if (div_q == bit_div_half(ratio)) begin
        pins_o.bit_clock <= 1'b1;
      end
    end
  end

  // ******************************************************************
  // Serializer
  // ******************************************************************
  serial_pins_t sel;
  serial_pins_t prev_q;
  logic [19:0] left_q;
  logic [19:0] right_q;
  logic [19:0] word_q;
  logic [4:0] ptr_q;
  logic lr_edge;
  logic left_phase;
  logic [19:0] word_nx;
  logic [4:0] ptr_nx;
  logic bck_rise;
  logic bck_fall;

  // Slave frames of 64, 48 or 32 bits all work: timing is edge driven
  assign sel = master_q ? pins_o : ser_s2_q;
  assign lr_edge = core_on && (sel.lr != prev_q.lr);
  assign lr_rise = lr_edge && sel.lr;
  assign bck_rise = sel.bit_clock && !prev_q.bit_clock;
  assign bck_fall = !sel.bit_clock && prev_q.bit_clock;
  assign left_phase = (format_q == FMT_I2S20) ? ~sel.lr : sel.lr;
  assign word_nx = lr_edge ? (left_phase ? left_q : right_q) : word_q;
  assign ptr_nx = lr_edge ? 5'h00 : ptr_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prev_q <= '0;
    end else begin
      prev_q <= sel;
    end
  end

  // A 16-bit word is kept MSB aligned so one bit pointer serves all
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !core_on) begin
      left_q <= 20'h00000;
      right_q <= 20'h00000;
    end else if (sample_valid_i) begin
      if (format_q == FMT_RJ16) begin
        left_q <= {sample_left_i[19:4], 4'h0};
        right_q <= {sample_right_i[19:4], 4'h0};
      end else begin
        left_q <= sample_left_i;
        right_q <= sample_right_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !core_on) begin
      word_q <= 20'h00000;
      ptr_q <= 5'h00;
    end else begin
      word_q <= word_nx;
      if (lr_edge) begin
        ptr_q <= 5'h00;
      end else if (bck_rise && sel.fv && ptr_q != WORD_MSB) begin
        ptr_q <= ptr_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || state_q != ST_RUN) begin
      data_out_o <= 1'b0;
    end else if (bck_fall || lr_edge) begin
      data_out_o <= sel.fv && !ctrl_q[CTRL_MUTE_BIT] &&
                    word_nx[WORD_MSB - ptr_nx];
    end
  end

  // ******************************************************************
  // APB slave
  // ******************************************************************
  logic [31:0] rd_mux;
  logic mapped;

  always_comb begin
    rd_mux = 32'h00000000;
    mapped = 1'b1;
    case (paddr_i)
      REG_CTRL: rd_mux = {30'h00000000, ctrl_q};
      REG_STATUS: rd_mux = {24'h000000, state_q == ST_RUN, format_q,
                            master_q, ratio, 2'(state_q)};
      REG_LEFT: rd_mux = {12'h000, left_q};
      REG_RIGHT: rd_mux = {12'h000, right_q};
      default: mapped = 1'b0;
    endcase
  end

  // Zero wait states: ready rises in the first access cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      pready_o <= psel_i && !penable_i;
      if (psel_i && !penable_i) begin
        pslverr_o <= !mapped;
        prdata_o <= pwrite_i ? 32'h00000000 : rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (psel_i && penable_i && pready_o && pwrite_i &&
                 paddr_i == REG_CTRL) begin
      ctrl_q <= pwdata_i[1:0];
    end
  end

endmodule

// [bench/audio_port_asserts.sv]
// Concurrent checks on the serial audio port outputs
`timescale 1ns/10ps
module audio_port_asserts
  import audio_port_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic sys_rst_i, // Sync reset
  input wire logic reset_n_in_i, // Reset pin
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pready_o, // APB ready
  input wire serial_pins_t pins_o, // Clock pins out
  input wire serial_pins_t pins_oe_o, // Pin enables
  input wire logic data_out_o, // Serial data
  input wire logic filter_run_o // Filter enable
);
  // ********
  // Frame counters
  // ********
  logic [6:0] bk_q;
  logic [1:0] fr_q;
  logic seen_q;
  logic [10:0] hold_q;
  serial_pins_t prev_q;
  wire logic lr_up = pins_o.lr && !prev_q.lr;
  wire logic fv_up = pins_o.fv && !prev_q.fv;
  always_ff @(posedge clk_i) prev_q <= pins_o;
  // The fv rise that shares an edge with lr belongs to the new frame
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !reset_n_in_i || !pins_oe_o.bit_clock) begin
      bk_q <= 7'h0;
      fr_q <= 2'h0;
      seen_q <= 1'b0;
    end else begin
      bk_q <= lr_up ? 7'h0 : bk_q + 7'(pins_o.bit_clock && !prev_q.bit_clock);
      fr_q <= lr_up ? 2'(fv_up) : fr_q + 2'(fv_up);
      seen_q <= seen_q || lr_up;
    end
  end
  // Saturates so a long run never wraps under the hold figure
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !reset_n_in_i) begin
      hold_q <= 11'h0;
    end else if (hold_q != 11'h7FF) begin
      hold_q <= hold_q + 11'h1;
    end
  end
  // ********
  // Properties
  // ********
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_rst_quiet: assert property (
    (!reset_n_in_i) [*6] |-> !data_out_o && !filter_run_o)
    else $error("Data or filter active in reset");
  chk_rst_halt: assert property (
    (!reset_n_in_i) [*6] |-> pins_o == 3'h0)
    else $error("Clock pins run in reset");
  chk_hold_len: assert property (
    $rose(filter_run_o) |-> hold_q >= 11'h400 && hold_q <= 11'h410)
    else $error("Filter started outside the hold window");
  chk_wake_bound: assert property (
    hold_q == 11'h410 |-> filter_run_o)
    else $error("Filter did not start after hold");
  chk_bit_count: assert property (
    lr_up && seen_q |-> bk_q == 7'h40)
    else $error("Bit clocks per frame wrong");
  chk_fv_rate: assert property (
    lr_up && seen_q |-> fr_q == 2'h2)
    else $error("Frame valid count per frame wrong");
  chk_fv_gate: assert property (
    pins_oe_o.fv && !pins_o.fv && !$past(pins_o.fv) |-> !data_out_o)
    else $error("Data outside frame valid");
  chk_data_edge: assert property (
    filter_run_o && $past(filter_run_o) && pins_oe_o.bit_clock &&
    $changed(data_out_o) |-> !$past(pins_o.bit_clock) && $past(pins_o.bit_clock, 2))
    else $error("Data moved away from bit clock fall");
  chk_slave_idle: assert property (
    !pins_oe_o.bit_clock |-> pins_o == 3'h0)
    else $error("Undriven clock pins not low");
  chk_apb_ready: assert property (
    psel_i && !penable_i |=> pready_o)
    else $error("APB access not answered");
  cover property ($rose(filter_run_o));
  cover property (lr_up && seen_q);
  cover property (!pins_oe_o.bit_clock && filter_run_o);
endmodule

// [bench/audio_serial_host.sv]
// Serial audio controller and receiver facing the port
`timescale 1ns/10ps
module audio_serial_host
  import audio_port_pkg::*;
#(
  parameter int HALF = 4 // Clocks per bit clock half
) (
  input wire logic clk_i, // System clock
  input wire logic drive_i, // Drive clocks, slave
  input wire format_t fmt_i, // Format in use
  input wire serial_pins_t line_i, // Pin levels
  input wire logic data_i, // Serial data
  output serial_pins_t pins_o, // Clocks driven
  output logic [19:0] left_o = 20'h0, // Last left word
  output logic [19:0] right_o = 20'h0, // Last right word
  output logic [7:0] words_o = 8'h0 // Words seen
);
  // ********
  // Clock generation
  // ********
  logic [9:0] cnt_q = 10'h0;
  int bit_n;
  always_comb bit_n = int'(cnt_q) / (2 * HALF);
  function automatic logic fv_on(input format_t f, input int s);
    case (f)
      FMT_LJ20: return s < 20;
      FMT_I2S20: return s >= 1 && s <= 20;
      FMT_RJ16: return s >= 16;
      default: return s >= 12;
    endcase
  endfunction
  // Clocks stand still while not in use
  always_ff @(posedge clk_i) begin
    if (!drive_i) begin
      cnt_q <= 10'h0;
      pins_o <= 3'h0;
    end else begin
      cnt_q <= (int'(cnt_q) == 128 * HALF - 1) ? 10'h0 : cnt_q + 10'h1;
      pins_o.bit_clock <= (int'(cnt_q) % (2 * HALF)) >= HALF;
      pins_o.lr <= (bit_n < 32) ^ (fmt_i == FMT_I2S20);
      pins_o.fv <= fv_on(fmt_i, bit_n % 32);
    end
  end
  // ********
  // Receiver
  // ********
  serial_pins_t old_q;
  logic [19:0] sh_q;
  logic lr_w_q;
  always_ff @(posedge clk_i) begin
    old_q <= line_i;
    if (line_i.bit_clock && !old_q.bit_clock && line_i.fv)
      sh_q <= {sh_q[18:0], data_i};
    if (line_i.fv && !old_q.fv)
      lr_w_q <= line_i.lr;
    if (!line_i.fv && old_q.fv) begin
      if (lr_w_q ^ (fmt_i == FMT_I2S20))
        left_o <= sh_q;
      else
        right_o <= sh_q;
      words_o <= words_o + 8'h1;
    end
  end
endmodule

// [bench/audio_port_test.sv]
// Testbench for the serial audio output port
`timescale 1ns/10ps
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, e); \
  end \
end
module audio_port_test;
  import audio_port_pkg::*;
  // ********
  // Clock, reset and design
  // ********
  localparam int VF = 4;
  localparam int LIMIT = 30000;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reset_n_in_i = 1'b0;
  logic [1:0] iface = 2'h0;
  logic [1:0] fmt = 2'h0;
  logic [1:0] fpin = 2'h0;
  logic drive = 1'b0;
  serial_pins_t pins_i, pins_o, pins_oe_o, host_pins;
  logic data_out_o, filter_tick_o, filter_run_o;
  logic sample_valid_i = 1'b0;
  logic [19:0] sample_left_i = 20'h0, sample_right_i = 20'h0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h0;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic pready_o, pslverr_o;
  logic [19:0] got_l, got_r;
  logic [7:0] words;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  always #5 clk_i = ~clk_i;
  assign pins_i = (pins_oe_o & pins_o) | (~pins_oe_o & host_pins);
  audio_port #(.VALID_FRAMES(VF)) audio_port_i (.clk_i, .sys_rst_i,
    .reset_n_in_i, .iface_sel_hi_i(iface[1]), .iface_sel_lo_i(iface[0]),
    .format_sel_hi_i(fpin[1]), .format_sel_lo_i(fpin[0]), .pins_i,
    .pins_o, .pins_oe_o, .data_out_o, .sample_valid_i, .sample_left_i,
    .sample_right_i, .filter_tick_o, .filter_run_o, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o);
  audio_serial_host #(.HALF(4)) audio_serial_host_i (.clk_i,
    .drive_i(drive), .fmt_i(format_t'(fmt)), .line_i(pins_i),
    .data_i(data_out_o), .pins_o(host_pins), .left_o(got_l),
    .right_o(got_r), .words_o(words));
  // ********
  // Tasks
  // ********
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Only the bench watchdog ends a wait for ready
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_words;
    logic [7:0] w0;
    int n;
    w0 = words;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (8'(words - w0) < 8'h6 && n < 4000);
  endtask
  task automatic bring_up(input logic [1:0] md, input logic [1:0] fm);
    logic [31:0] r;
    logic e;
    int n;
    int f;
    int t;
    logic [19:0] sl;
    logic [19:0] sr;
    sl = {1'b1, md, fm, 15'h2C93};
    sr = {1'b0, fm, md, 15'h5A31};
    f = (md == IFACE_M384) ? 384 : (md == IFACE_M256) ? 256 : 512;
    iface <= md;
    fmt <= fm;
    fpin <= fm;
    drive <= (md == IFACE_SLAVE);
    reset_n_in_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    `CHK(data_out_o, 1'b0)
    `CHK(pins_o, 3'h0)
    `CHK(filter_run_o, 1'b0)
    reset_n_in_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (filter_run_o !== 1'b1 && n < 2000);
    `CHK(n >= 1024 && n <= 1036, 1'b1)
    sample_valid_i <= 1'b1;
    sample_left_i <= sl;
    sample_right_i <= sr;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    n = 1;
    do begin
      apb(1'b0, REG_STATUS, 32'h0, r, e);
      n += 3;
    end while (r[7] !== 1'b1 && n < 4000);
    `CHK(n >= (VF - 1) * f && n <= VF * f + 16, 1'b1)
    `CHK(r[6:0], {fm, md != IFACE_SLAVE, 2'((md == 2'h0) ? 2 : 3 - md),
      2'h3})
    fpin <= ~fm;
    wait_words;
    `CHK(got_l, (fm == FMT_RJ16) ? {got_l[19:16], sl[19:4]} : sl)
    `CHK(got_r, (fm == FMT_RJ16) ? {got_r[19:16], sr[19:4]} : sr)
    `CHK(pins_oe_o, {3{md != IFACE_SLAVE}})
    // One frame of system clocks must hold exactly 256 filter ticks
    t = 0;
    repeat (f) begin
      @(posedge clk_i);
      t += int'(filter_tick_o);
    end
    `CHK(t, 256)
  endtask
  task automatic reg_access;
    logic [31:0] r;
    logic e;
    apb(1'b1, REG_CTRL, 32'h1, r, e);
    apb(1'b0, REG_CTRL, 32'h0, r, e);
    `CHK({e, r}, {1'b0, 32'h1})
    apb(1'b0, REG_LEFT, 32'h0, r, e);
    `CHK(r[19:0], {1'b1, 2'h0, 2'h3, 15'h2C93})
    wait_words;
    `CHK({got_l, got_r}, 40'h0)
    apb(1'b0, 8'h10, 32'h0, r, e);
    `CHK({e, r}, {1'b1, 32'h0})
    apb(1'b1, REG_CTRL, 32'h0, r, e);
  endtask
  // ********
  // Sequence
  // ********
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 4; i++)
      bring_up(2'(i + 1), 2'(i));
    reg_access;
    print_verdict;
  end
endmodule
bind audio_port audio_port_asserts audio_port_asserts_i (.clk_i, .sys_rst_i,
  .reset_n_in_i, .psel_i, .penable_i, .pready_o, .pins_o, .pins_oe_o,
  .data_out_o, .filter_run_o);
